// ==== hdl/srf_reply_formatter.sv ====
// Sensor reply formatter top: takes a reply request and streams the ASCII
// reply one character per cycle, or nothing on an address mismatch.
// Assumes requests, flags and identity fields come from same-clock logic
// and the sink takes one character per cycle when charReady is high.
//
// Overview of operation
// RL1 - Error word sent as four hex digits
// RL2 - Bit 0 flags missing factory compensation
// RL3 - Bits 1-7 flag computational faults
// RL4 - Over range clamps output, sets bit 8
// RL5 - Bits 9-15 reserved, no meaning
// RL6 - Other faults force output to 8000
// RL7 - Serial number twelve characters, two hyphens
// RL8 - Month letters A to M skipping I
// RL9 - Serial fields kept within their ranges
// RL10 - Mismatched addressed serial gives silence
// RL11 - Temperature reply: low, space, high, space, C
// RL12 - Reading reply: prefix, output, space, error
// RL13 - Every reply ends with carriage return
// RL14 - Upper case hex, reserved bits zero
`timescale 1ns/1ps
`default_nettype none
module srf_reply_formatter
  import srf_pkg::*;
(
  input  wire logic        clk,          // System clock, 125 MHz
  input  wire logic        rst,          // Async reset, active high
  input  wire logic        reqValid,     // Request strobe
  input  wire srf_req_t    req,          // Request contents
  input  wire srf_serial_t ownSerial,    // Device serial number
  input  wire srf_temp_t   tempRange,    // Compensated range
  input  wire logic        uncal,        // Not compensated
  input  wire logic [6:0]  calcFault,    // Computational faults
  input  wire logic        overRange,    // Pressure beyond range
  input  wire logic        overHigh,     // High side when set
  input  wire logic [15:0] rawOutput,    // Converted pressure
  input  wire logic [15:0] limitHigh,    // Upper clamp
  input  wire logic [15:0] limitLow,     // Lower clamp
  input  wire logic        charReady,    // Sink accepts character
  output var  logic        reqReady,     // Idle, request taken
  output var  srf_char_t   charOut,      // Outgoing character
  output var  logic        serialBad     // Own serial out of range
);

  // ------------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    SRF_IDLE = 2'b00,  // Waiting for a request
    SRF_SEND = 2'b01   // Streaming characters
  } srf_state_t;

  srf_state_t  state_ff;                // Sequencer state
  srf_kind_t   kind_ff;                 // Reply being sent
  logic [3:0]  index_ff;                // Character position
  logic [15:0] errSnap_ff;              // Error word held for the reply
  logic [15:0] outSnap_ff;              // Output held for the reply
  logic [15:0] errWord;                 // Live error word
  logic [15:0] outWord;                 // Live output value
  logic [7:0]  hexChar [4];             // Encoded hex digits
  logic [3:0]  hexNib  [4];             // Nibble per digit
  logic [7:0]  nxt_char;                // Character at index
  logic        nxt_last;                // Final character flag
  logic        match;                   // Addressed serial matches
  logic [7:0]  monthChar;               // Month letter
  logic [7:0]  tempChars [8];           // Temperature reply text
  logic [3:0]  tempLen;                 // Temperature reply length

  // ------------------------------------------------------------------
  // Error word and output value
  // ------------------------------------------------------------------
  srf_error_word u_err (
    .clk       (clk),
    .rst       (rst),
    .uncal     (uncal),
    .calcFault (calcFault),
    .overRange (overRange),
    .overHigh  (overHigh),
    .rawOutput (rawOutput),
    .limitHigh (limitHigh),
    .limitLow  (limitLow),
    .errWord   (errWord),
    .outWord   (outWord)
  );

  // ------------------------------------------------------------------
  // Hex encoders
  // ------------------------------------------------------------------
  // Shared by both four-digit fields; index picks the word
  generate
    for (genvar g = 0; g < 4; g++)
    begin : gen_hex
      srf_hex_digit u_hex (
        .nibble (hexNib[g]),
        .ascii  (hexChar[g])
      );
    end
  endgenerate

  // Output digits at 3..6, error digits at 8..11; most significant first
  always_comb
  begin
    for (int k = 0; k < 4; k++)
    begin
      if (index_ff < 4'd8)
      begin
        hexNib[k] = outSnap_ff[15 - 4*k -: 4];  // RL1
      end
      else
      begin
        hexNib[k] = errSnap_ff[15 - 4*k -: 4];  // RL1
      end
    end
  end

  // ------------------------------------------------------------------
  // Address match and field checks
  // ------------------------------------------------------------------
  assign match = !req.addressed || (req.addrSerial == ownSerial);  // RL10

  // Month letter, I skipped from September on
  always_comb
  begin
    if (ownSerial.month >= SRF_MONTH_SKIP)
    begin
      monthChar = SRF_CHAR_UPA + {4'h0, ownSerial.month};  // RL8
    end
    else
    begin
      monthChar = SRF_CHAR_UPA + {4'h0, ownSerial.month - SRF_MONTH_MIN};  // RL8
    end
  end

  // Flag an identity that cannot be printed correctly
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      serialBad <= 1'b0;
    end
    else
    begin
      serialBad <= (ownSerial.year > SRF_YEAR_MAX)          // RL9
                || (ownSerial.month < SRF_MONTH_MIN)
                || (ownSerial.month > SRF_MONTH_MAX)
                || (ownSerial.batch > SRF_BATCH_MAX)
                || (ownSerial.slot < SRF_SLOT_MIN)
                || (ownSerial.slot > SRF_SLOT_MAX)
                || (ownSerial.position < SRF_POS_MIN);
    end
  end

  // ------------------------------------------------------------------
  // Temperature text
  // ------------------------------------------------------------------
  // Two digit magnitudes only; a three digit range would need more slots
  function automatic logic [15:0] srf_dec2(input logic signed [7:0] v);
    logic [7:0] mag;
    mag = v[7] ? 8'(-v) : v;
    srf_dec2 = {SRF_CHAR_ZERO + 8'(mag / 8'd10), SRF_CHAR_ZERO + 8'(mag % 8'd10)};
  endfunction

  always_comb
  begin
    logic [15:0] lo;
    logic [15:0] hi;
    lo = srf_dec2(tempRange.low);
    hi = srf_dec2(tempRange.high);
    tempChars[0] = tempRange.low[7] ? SRF_CHAR_MINUS : SRF_CHAR_SPACE;
    tempChars[1] = lo[15:8];
    tempChars[2] = lo[7:0];
    tempChars[3] = SRF_CHAR_SPACE;  // RL11
    tempChars[4] = hi[15:8];
    tempChars[5] = hi[7:0];
    tempChars[6] = SRF_CHAR_SPACE;  // RL11
    tempChars[7] = SRF_CHAR_UPC;    // RL11
    tempLen = 4'd8;
  end

  // ------------------------------------------------------------------
  // Character selection
  // ------------------------------------------------------------------
  always_comb
  begin
    nxt_char = SRF_CHAR_CR;
    nxt_last = 1'b0;
    unique case (kind_ff)
      SRF_REPLY_READING:
      begin
        // Prefix, output, space, error word, delimiter
        unique case (index_ff)
          4'd0:  nxt_char = SRF_CHAR_UPR;    // RL12
          4'd1:  nxt_char = SRF_CHAR_UPL;    // RL12
          4'd2:  nxt_char = SRF_CHAR_EQUAL;  // RL12
          4'd3:  nxt_char = hexChar[0];
          4'd4:  nxt_char = hexChar[1];
          4'd5:  nxt_char = hexChar[2];
          4'd6:  nxt_char = hexChar[3];
          4'd7:  nxt_char = SRF_CHAR_SPACE;  // RL12
          4'd8:  nxt_char = hexChar[0];
          4'd9:  nxt_char = hexChar[1];
          4'd10: nxt_char = hexChar[2];
          4'd11: nxt_char = hexChar[3];
          default:
          begin
            nxt_char = SRF_CHAR_CR;  // RL13
            nxt_last = 1'b1;
          end
        endcase
      end
      SRF_REPLY_SERIAL:
      begin
        // YMDD-NN-BSPP then delimiter
        unique case (index_ff)
          4'd0:  nxt_char = SRF_CHAR_ZERO + {4'h0, ownSerial.year};  // RL7
          4'd1:  nxt_char = monthChar;  // RL7
          4'd2:  nxt_char = SRF_CHAR_ZERO + {4'h0, ownSerial.day[7:4]};
          4'd3:  nxt_char = SRF_CHAR_ZERO + {4'h0, ownSerial.day[3:0]};
          4'd4:  nxt_char = SRF_CHAR_HYPHEN;  // RL7
          4'd5:  nxt_char = SRF_CHAR_ZERO + {4'h0, ownSerial.lot[7:4]};
          4'd6:  nxt_char = SRF_CHAR_ZERO + {4'h0, ownSerial.lot[3:0]};
          4'd7:  nxt_char = SRF_CHAR_HYPHEN;  // RL7
          4'd8:  nxt_char = SRF_CHAR_UPA + {3'h0, ownSerial.batch};  // RL9
          4'd9:  nxt_char = SRF_CHAR_ZERO + {5'h00, ownSerial.slot};  // RL9
          4'd10: nxt_char = SRF_CHAR_ZERO + {4'h0, 4'(ownSerial.position / 4'd10)};
          4'd11: nxt_char = SRF_CHAR_ZERO + {4'h0, 4'(ownSerial.position % 4'd10)};
          default:
          begin
            nxt_char = SRF_CHAR_CR;  // RL13
            nxt_last = 1'b1;
          end
        endcase
      end
      default:
      begin
        // Temperature range text then delimiter
        if (index_ff < tempLen)
        begin
          nxt_char = tempChars[index_ff[2:0]];
        end
        else
        begin
          nxt_char = SRF_CHAR_CR;  // RL13
          nxt_last = 1'b1;
        end
      end
    endcase
  end

  // ------------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------------
  // Snapshots keep one reply consistent while flags move
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_ff   <= SRF_IDLE;
      kind_ff    <= SRF_REPLY_READING;
      index_ff   <= 4'h0;
      errSnap_ff <= SRF_ERR_RESET;
      outSnap_ff <= SRF_OUT_RESET;
    end
    else
    begin
      unique case (state_ff)
        SRF_IDLE:
        begin
          if (reqValid && match)
          begin
            state_ff   <= SRF_SEND;
            kind_ff    <= req.kind;
            index_ff   <= 4'h0;
            errSnap_ff <= errWord;
            outSnap_ff <= outWord;
          end
          // Mismatch: request dropped, line left silent  RL10
        end
        SRF_SEND:
        begin
          if (!charOut.valid || charReady)
          begin
            if (nxt_last)
            begin
              state_ff <= SRF_IDLE;
            end
            else
            begin
              index_ff <= index_ff + 4'h1;
            end
          end
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Output register
  // ------------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      charOut  <= '0;
      reqReady <= 1'b0;
    end
    else
    begin
      reqReady <= (state_ff == SRF_IDLE) && !reqValid;
      if (charOut.valid && !charReady)
      begin
        charOut <= charOut;  // Held under back-pressure
      end
      else if (state_ff == SRF_SEND)
      begin
        charOut <= '{valid: 1'b1, data: nxt_char, last: nxt_last};
      end
      else
      begin
        charOut <= '0;
      end
    end
  end

endmodule
`default_nettype wire

// ==== pkg/srf_pkg.sv ====
// Package for the sensor reply formatter: character codes, field layouts,
// error word bit positions and the request/character carriers.
// Assumes the importing modules run on one clock with an active high reset.
package srf_pkg;

  // ------------------------------------------------------------------
  // Character codes
  // ------------------------------------------------------------------
  localparam logic [7:0] SRF_CHAR_CR     = 8'h0_D;  // Message delimiter
  localparam logic [7:0] SRF_CHAR_SPACE  = 8'h2_0;  // Field separator
  localparam logic [7:0] SRF_CHAR_HYPHEN = 8'h2_D;  // Serial number separator
  localparam logic [7:0] SRF_CHAR_MINUS  = 8'h2_D;  // Negative sign
  localparam logic [7:0] SRF_CHAR_ZERO   = 8'h3_0;  // Digit zero
  localparam logic [7:0] SRF_CHAR_UPA    = 8'h4_1;  // Upper case A
  localparam logic [7:0] SRF_CHAR_UPC    = 8'h4_3;  // Letter C, degrees
  localparam logic [7:0] SRF_CHAR_UPI    = 8'h4_9;  // Letter I, skipped in months
  localparam logic [7:0] SRF_CHAR_UPL    = 8'h4_C;  // Letter L of the prefix
  localparam logic [7:0] SRF_CHAR_UPR    = 8'h5_2;  // Letter R of the prefix
  localparam logic [7:0] SRF_CHAR_EQUAL  = 8'h3_D;  // Prefix terminator
  localparam logic [7:0] SRF_CHAR_UPZ    = 8'h5_A;  // Upper case Z

  // ------------------------------------------------------------------
  // Error word layout
  // ------------------------------------------------------------------
  localparam int SRF_ERR_WIDTH       = 16;
  localparam int SRF_ERR_UNCAL_BIT   = 0;
  localparam int SRF_ERR_TIDX_OVF    = 1;
  localparam int SRF_ERR_TIDX_RNG    = 2;
  localparam int SRF_ERR_PIDX_RNG    = 3;
  localparam int SRF_ERR_CALC_LO     = 1;
  localparam int SRF_ERR_CALC_HI     = 7;
  localparam int SRF_ERR_PWL_OVF     = 5;
  localparam int SRF_ERR_SCALE_OVF   = 6;
  localparam int SRF_ERR_HIRES_OVF   = 7;
  localparam int SRF_ERR_LIMIT_BIT   = 8;
  localparam int SRF_ERR_RSVD_LO     = 9;
  localparam logic [15:0] SRF_ERR_RESET   = 16'h0000;
  localparam logic [15:0] SRF_OUT_FAULT   = 16'h8000;  // Forced output on fault
  localparam logic [15:0] SRF_OUT_RESET   = 16'h0000;
  localparam logic [7:0]  SRF_CALC_MASK   = 8'hFE;     // Bits 1..7 of the low byte

  // ------------------------------------------------------------------
  // Serial number layout and field limits
  // ------------------------------------------------------------------
  localparam int SRF_SN_LEN       = 12;
  localparam int SRF_SN_HYPHEN_A  = 4;   // Index of first hyphen
  localparam int SRF_SN_HYPHEN_B  = 7;   // Index of second hyphen
  localparam logic [3:0] SRF_YEAR_MAX  = 4'h9;
  localparam logic [3:0] SRF_MONTH_MIN = 4'h1;
  localparam logic [3:0] SRF_MONTH_MAX = 4'hC;
  localparam logic [3:0] SRF_MONTH_SKIP = 4'h9;  // From September the I is skipped
  localparam logic [2:0] SRF_SLOT_MIN  = 3'h1;
  localparam logic [2:0] SRF_SLOT_MAX  = 3'h5;
  localparam logic [3:0] SRF_POS_MIN   = 4'h1;
  localparam logic [3:0] SRF_POS_MAX   = 4'hF;
  localparam logic [4:0] SRF_BATCH_MAX = 5'h19;  // Z is letter 25 from A

  // ------------------------------------------------------------------
  // Reply kinds and carriers
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    SRF_REPLY_READING = 2'b00,  // Reading prefix, output, error word
    SRF_REPLY_SERIAL  = 2'b01,  // Serial number string
    SRF_REPLY_TEMP    = 2'b10   // Temperature range string
  } srf_kind_t;

  // Serial number fields, binary coded
  typedef struct packed {
    logic [3:0] year;      // 0..9
    logic [3:0] month;     // 1..12
    logic [7:0] day;       // Two BCD digits
    logic [7:0] lot;       // Two BCD digits
    logic [4:0] batch;     // 0..25 = A..Z
    logic [2:0] slot;      // 1..5
    logic [3:0] position;  // 1..15
  } srf_serial_t;

  // Compensated temperature range, signed degrees
  typedef struct packed {
    logic signed [7:0] low;
    logic signed [7:0] high;
  } srf_temp_t;

  // One reply request
  typedef struct packed {
    srf_kind_t   kind;
    logic        addressed;  // Command carried a serial number
    srf_serial_t addrSerial; // Serial number in the command
  } srf_req_t;

  // One outgoing character
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       last;
  } srf_char_t;

  localparam int SRF_MAX_LEN = 14;  // One above the longest reply, 13 characters with delimiter

endpackage

// ==== hdl/srf_hex_digit.sv ====
// Hex digit encoder: one nibble to one upper case ASCII character.
// Pure combinational; used by the reply sequencer for every hex field.
`timescale 1ns/1ps
`default_nettype none
module srf_hex_digit
  import srf_pkg::*;
(
  input  wire logic [3:0] nibble,  // Value 0..15
  output var  logic [7:0] ascii    // Character 0-9, A-F
);

  // ------------------------------------------------------------------
  // Encoding
  // ------------------------------------------------------------------
  // Letters are upper case only, hosts compare literally
  always_comb
  begin
    if (nibble < 4'hA)
    begin
      ascii = SRF_CHAR_ZERO + {4'h0, nibble};
    end
    else
    begin
      ascii = SRF_CHAR_UPA + {4'h0, nibble - 4'hA};  // RL14
    end
  end

endmodule
`default_nettype wire

// ==== hdl/srf_error_word.sv ====
// Error word builder: packs fault flags into the 16-bit error word and
// chooses the reported output value.
// Assumes flags are levels from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module srf_error_word
  import srf_pkg::*;
(
  input  wire logic        clk,         // System clock
  input  wire logic        rst,         // Async reset, active high
  input  wire logic        uncal,       // Not factory compensated
  input  wire logic [6:0]  calcFault,   // Faults on bits 1..7, bit 4 unused
  input  wire logic        overRange,   // Pressure beyond range
  input  wire logic        overHigh,    // Beyond high side when set
  input  wire logic [15:0] rawOutput,   // Converted pressure
  input  wire logic [15:0] limitHigh,   // Upper clamp value
  input  wire logic [15:0] limitLow,    // Lower clamp value
  output var  logic [15:0] errWord,     // Packed error word
  output var  logic [15:0] outWord      // Reported output value
);

  logic [15:0] nxt_errWord;  // Next error word
  logic [15:0] nxt_outWord;  // Next output value

  // ------------------------------------------------------------------
  // Packing
  // ------------------------------------------------------------------
  // Reserved field and the unused bit 4 held at zero
  always_comb
  begin
    nxt_errWord = SRF_ERR_RESET;  // RL5 RL14
    nxt_errWord[SRF_ERR_UNCAL_BIT] = uncal;  // RL2
    nxt_errWord[SRF_ERR_TIDX_OVF]  = calcFault[0];  // RL3
    nxt_errWord[SRF_ERR_TIDX_RNG]  = calcFault[1];  // RL3
    nxt_errWord[SRF_ERR_PIDX_RNG]  = calcFault[2];  // RL3
    nxt_errWord[SRF_ERR_PWL_OVF]   = calcFault[4];  // RL3
    nxt_errWord[SRF_ERR_SCALE_OVF] = calcFault[5];  // RL3
    nxt_errWord[SRF_ERR_HIRES_OVF] = calcFault[6];  // RL3
    nxt_errWord[SRF_ERR_LIMIT_BIT] = overRange;  // RL4
  end

  // Fault forces the marker; range limit alone clamps instead
  always_comb
  begin
    if (|nxt_errWord[SRF_ERR_CALC_HI:SRF_ERR_UNCAL_BIT])
    begin
      nxt_outWord = SRF_OUT_FAULT;  // RL6
    end
    else if (overRange)
    begin
      nxt_outWord = overHigh ? limitHigh : limitLow;  // RL4
    end
    else
    begin
      nxt_outWord = rawOutput;
    end
  end

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      errWord <= SRF_ERR_RESET;
      outWord <= SRF_OUT_RESET;
    end
    else
    begin
      errWord <= nxt_errWord;  // RL1
      outWord <= nxt_outWord;
    end
  end

endmodule
`default_nettype wire

// ==== bench/srf_reply_formatter_chk.sv ====
// Checker for the sensor reply formatter: timing and framing of replies.
// Assumes one clock domain and an async active high reset; bound below.
`timescale 1ns/1ps
`default_nettype none
module srf_reply_formatter_chk
  import srf_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        reqValid,
  input  wire srf_req_t    req,
  input  wire srf_serial_t ownSerial,
  input  wire logic        charReady,
  input  wire logic        reqReady,
  input  wire srf_char_t   charOut,
  input  wire logic        serialBad
);
  // ----------------
  // Clocking and helpers
  // ----------------
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic bad;  // Own serial field outside its range
  assign bad = ownSerial.year > SRF_YEAR_MAX || ownSerial.month < SRF_MONTH_MIN
    || ownSerial.month > SRF_MONTH_MAX || ownSerial.batch > SRF_BATCH_MAX
    || ownSerial.slot < SRF_SLOT_MIN || ownSerial.slot > SRF_SLOT_MAX
    || ownSerial.position < SRF_POS_MIN;
  // Plain reading request taken while idle
  sequence rdTaken;
    reqReady && reqValid && req.kind == SRF_REPLY_READING && !req.addressed;
  endsequence
  // Addressed request for some other part
  sequence missTaken;
    reqReady && reqValid && req.addressed && req.addrSerial != ownSerial;
  endsequence
  // ----------------
  // Assertions
  // ----------------
  AST_START: assert property (rdTaken ##1 (!charOut.valid || charReady)
    |=> charOut.valid && charOut.data == SRF_CHAR_UPR) else $error("reply not started with R");
  AST_PREFIX: assert property (rdTaken ##1 charReady [*4]
    |-> charOut.data == SRF_CHAR_EQUAL) else $error("prefix lacks equals sign");
  AST_SILENT: assert property (missTaken |=> !charOut.valid [*4])
    else $error("output after foreign serial");
  AST_HOLD: assert property (charOut.valid && !charReady |=> $stable(charOut))
    else $error("char changed while stalled");
  AST_LAST_CR: assert property (charOut.valid && charOut.last
    |-> charOut.data == SRF_CHAR_CR) else $error("last char not carriage return");
  AST_END_GAP: assert property (charOut.valid && charOut.last && charReady
    |=> !charOut.valid) else $error("output after delimiter");
  AST_UPPER: assert property (charOut.valid |-> !(charOut.data inside {[8'h61:8'h7A]}))
    else $error("lower case letter sent");
  AST_BAD_SET: assert property (bad [*3] |-> serialBad)
    else $error("bad serial field not flagged");
  AST_BAD_CLR: assert property (!bad [*3] |-> !serialBad)
    else $error("good serial flagged bad");
endmodule
bind srf_reply_formatter srf_reply_formatter_chk u_chk (.clk(clk), .rst(rst), .reqValid(reqValid),
  .req(req), .ownSerial(ownSerial), .charReady(charReady), .reqReady(reqReady),
  .charOut(charOut), .serialBad(serialBad));
`default_nettype wire

// ==== bench/srf_host_model.sv ====
// Host side sink: accepts reply characters, optionally stalling.
// Assumes the bench clears text between replies; frames are counted here.
`timescale 1ns/1ps
`default_nettype none
module srf_host_model
  import srf_pkg::*;
(
  input  wire logic      clk,
  input  wire logic      rst,
  input  wire srf_char_t charOut,
  input  wire logic      stall,
  output var  logic      charReady
);
  string text;    // Characters taken so far
  int    frames;  // Replies ended by the delimiter
  // Ready every cycle, or every other cycle when stalling
  always_ff @(posedge clk or posedge rst)
    if (rst)
      charReady <= 1'b0;
    else
      charReady <= !stall || !charReady;
  // Collect taken characters; a frame closes on the delimiter
  always @(posedge clk)
    if (!rst && charOut.valid && charReady)
    begin
      text = {text, string'(charOut.data)};
      if (charOut.last && charOut.data == SRF_CHAR_CR)
        frames++;
    end
endmodule
`default_nettype wire

// ==== bench/srf_reply_formatter_tb.sv ====
// Reply formatter bench: requests replies, compares the text.
// Assumes the host model collects characters.
`timescale 1ns/1ps
`default_nettype none
module srf_reply_formatter_tb;
  import srf_pkg::*;
  logic        clk = 0, rst = 1, reqValid = 0, stall = 0;
  logic        uncal = 0, overRange = 0, overHigh = 0;
  logic [6:0]  calcFault = '0;
  logic [15:0] rawOutput = 16'h1E43, limitHigh = 16'h3FF0, limitLow = 16'h0010;
  srf_req_t    req = '0;
  srf_serial_t own = '{4'h3, 4'h4, 8'h23, 8'h03, 5'h00, 3'h1, 4'h3};
  srf_temp_t   tempRange = '{-8'sd20, 8'sd85};
  logic        charReady, reqReady, serialBad;
  srf_char_t   charOut;
  int          mismatches = 0, total_checks = 0, cycles = 0;
  string       got;
  always #4 clk = ~clk;
  srf_reply_formatter u_srf_reply_formatter (.clk(clk), .rst(rst), .reqValid(reqValid),
    .req(req), .ownSerial(own), .tempRange(tempRange), .uncal(uncal),
    .calcFault(calcFault), .overRange(overRange), .overHigh(overHigh),
    .rawOutput(rawOutput), .limitHigh(limitHigh), .limitLow(limitLow),
    .charReady(charReady), .reqReady(reqReady), .charOut(charOut), .serialBad(serialBad));
  srf_host_model u_host (.clk(clk), .rst(rst), .charOut(charOut), .stall(stall),
    .charReady(charReady));
  // ----------------
  // Helpers
  // ----------------
  // Upper case hex, four digits
  function automatic string hx(logic [15:0] v);
    string d = "0123456789ABCDEF";
    hx = "";
    for (int i = 12; i >= 0; i -= 4)
      hx = {hx, string'(d[v[i+:4]])};
  endfunction
  function automatic string rd(logic [15:0] o, logic [15:0] e);
    rd = {"RL=", hx(o), " ", hx(e), "\015"};
  endfunction
  // Month letters skip I
  function automatic string sn(srf_serial_t s);
    string ml = "ABCDEFGHJKLM";
    sn = $sformatf("%0d%s%02h-%02h-%s%0d%02d\015", s.year,
      ml.substr(int'(s.month) - 1, int'(s.month) - 1), s.day, s.lot,
      string'(8'(8'h41 + s.batch)), s.slot, s.position);
  endfunction
  task automatic chk(string what, string exp, string act);
    total_checks++;
    if (exp != act)
    begin
      mismatches++;
      $display("Error %s expected %s seen %s", what, exp, act);
    end
  endtask
  // One request, then wait for the delimiter
  task automatic ask(srf_kind_t k, logic adr, srf_serial_t s);
    int n, f;
    u_host.text = "";
    f = u_host.frames;
    repeat (3) @(posedge clk);
    chk("reqReady", "1", $sformatf("%b", reqReady));
    reqValid <= 1'b1;
    req <= '{k, adr, s};
    @(posedge clk);
    reqValid <= 1'b0;
    for (n = 0; u_host.frames == f && n < 60; n++)
      @(posedge clk);
    got = u_host.text;
  endtask
  task automatic end_sim;
    if (mismatches == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // ----------------
  // Scenarios
  // ----------------
  task automatic t_reading;
    ask(SRF_REPLY_READING, 1'b0, '0);
    chk("reading", rd(16'h1E43, 16'h0000), got);
    stall <= 1'b1;  // Slow sink
    ask(SRF_REPLY_READING, 1'b0, '0);
    stall <= 1'b0;
    chk("stalled reading", rd(16'h1E43, 16'h0000), got);
  endtask
  task automatic t_faults;
    uncal <= 1'b1;
    ask(SRF_REPLY_READING, 1'b0, '0);
    uncal <= 1'b0;
    chk("uncompensated", rd(16'h8000, 16'h0001), got);
    for (int k = 0; k < 7; k++)
    begin
      calcFault <= 7'(1 << k);
      ask(SRF_REPLY_READING, 1'b0, '0);
      chk("calc", k == 3 ? rd(16'h1E43, 16'h0000) : rd(16'h8000, 16'(1 << (k + 1))), got);
    end
    calcFault <= 7'h7F;  // All at once, bit 4 stays clear
    ask(SRF_REPLY_READING, 1'b0, '0);
    calcFault <= '0;
    chk("all calc faults", rd(16'h8000, 16'h00EE), got);
  endtask
  task automatic t_range;
    overRange <= 1'b1;
    overHigh <= 1'b1;
    ask(SRF_REPLY_READING, 1'b0, '0);
    chk("over high", rd(16'h3FF0, 16'h0100), got);
    overHigh <= 1'b0;
    ask(SRF_REPLY_READING, 1'b0, '0);
    overRange <= 1'b0;
    chk("over low", rd(16'h0010, 16'h0100), got);
  endtask
  task automatic t_serial;
    srf_serial_t s;
    s = own;
    for (int m = 1; m <= 12; m++)
    begin
      s.month = 4'(m);
      if (m == 12)
        s = '{4'h9, 4'hC, 8'h31, 8'h99, 5'h19, 3'h5, 4'hF};
      own <= s;
      ask(SRF_REPLY_SERIAL, 1'b0, '0);
      chk("serial", sn(s), got);
    end
    chk("serial length", "13", $sformatf("%0d", got.len()));
  endtask
  task automatic t_temp;
    ask(SRF_REPLY_TEMP, 1'b0, '0);
    chk("temp", "-20 85 C\015", got);
    tempRange <= '{8'sd0, 8'sd70};
    ask(SRF_REPLY_TEMP, 1'b0, '0);
    chk("temp positive", " 00 70 C\015", got);
  endtask
  task automatic t_addr;
    srf_serial_t other;
    other = own;
    other.day = 8'h24;
    ask(SRF_REPLY_SERIAL, 1'b1, other);
    chk("foreign", "", got);
    ask(SRF_REPLY_SERIAL, 1'b1, own);
    chk("matching", sn(own), got);
  endtask
  task automatic t_bad;
    own.slot <= 3'h0;
    repeat (4) @(posedge clk);
    chk("serial bad", "1", $sformatf("%b", serialBad));
    own.slot <= 3'h5;
    repeat (4) @(posedge clk);
    chk("serial good", "0", $sformatf("%b", serialBad));
  endtask
  // ----------------
  // Timeout and main sequence
  // ----------------
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      end_sim();
    end
  end
  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_reading();
    t_faults();
    t_range();
    t_serial();
    t_temp();
    t_addr();
    t_bad();
    end_sim();
  end
endmodule
`default_nettype wire
